// ---- design/scsf_axil_slave.sv ----
// AXI4-Lite slave front end: decodes one write and one read at a time.
// Assumes the register core answers combinationally on the presented index.
`timescale 1ns/100ps
module scsf_axil_slave
  import scsf_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_wr_stb,
  output logic [7:0]       o_wr_addr,
  output logic [31:0]      o_wr_data,
  output logic [3:0]       o_wr_strb,
  input  wire logic        i_wr_ok,
  output logic             o_rd_stb,
  output logic [7:0]       o_rd_addr,
  input  wire logic [31:0] i_rd_data,
  input  wire logic        i_rd_ok
);

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } scsf_axs_t;

  scsf_axs_t st_r;
  scsf_axs_t st_nxt;

  assign o_awready = !st_r.aw_got && !st_r.bvalid;
  assign o_wready  = !st_r.w_got && !st_r.bvalid;
  assign o_arready = !st_r.rvalid;
  assign o_bvalid  = st_r.bvalid;
  assign o_bresp   = st_r.bresp;
  assign o_rvalid  = st_r.rvalid;
  assign o_rdata   = st_r.rdata;
  assign o_rresp   = st_r.rresp;
  assign o_wr_stb  = st_r.aw_got && st_r.w_got;
  assign o_wr_addr = st_r.awaddr;
  assign o_wr_data = st_r.wdata;
  assign o_wr_strb = st_r.wstrb;
  assign o_rd_stb  = i_arvalid && o_arready;
  assign o_rd_addr = i_araddr;

  always_comb begin
    st_nxt = st_r;
    if (i_awvalid && o_awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = i_wdata;
      st_nxt.wstrb = i_wstrb;
    end
    if (o_wr_stb) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = i_wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (o_rd_stb) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = i_rd_data;
      st_nxt.rresp  = i_rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ---- design/scsf_edge_detect.sv ----
// Carrier level change detector on an already synchronised input.
// Assumes the level is synchronous to i_clock.
`timescale 1ns/100ps
module scsf_edge_detect (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_level,
  output logic      o_level,
  output logic      o_change
);

  typedef struct packed {
    logic primed;
    logic level;
  } scsf_edg_t;

  scsf_edg_t st_r;
  scsf_edg_t st_nxt;

  assign o_level  = st_r.level;
  assign o_change = st_r.primed && (i_level != st_r.level);

  always_comb begin
    st_nxt        = st_r;
    st_nxt.primed = 1'b1;
    st_nxt.level  = i_level;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ---- design/scsf_status_flags.sv ----
// Channel interrupt status flags with mask, visibility and line status.
// Assumes event strobes are one-cycle pulses synchronous to i_clock.
//
// What this block does
// - Async mode: received parity failure sets status bit 5 if checking on.
// - With status byte option on, parity failure also lands in status byte.
// - Async mode: zero sampled at stop bit position sets status bit 4.
// - HDLC mode: bits 9..4 read zero; bit 0 always reads zero.
// - DPLL sync loss sets bit 3 when DPLL clocks receive with FM coding.
// - After sync loss, reception is held off until DPLL resynchronises.
// - Transmit clocked from DPLL also halts until resync after a sync loss caught with DPLL receive and FM.
// - Any carrier-detect transition sets bit 2; level readable in line status.
// - Receive data dropped on full FIFO sets status bit 1.
// - Masked flags appear in status only while show-masked bit is one.
// - Host writes one to clear a flag; zeros leave flags alone.
`timescale 1ns/100ps
module scsf_status_flags
  import scsf_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire scsf_event_t i_event,
  output logic             o_rx_enable,
  output logic             o_tx_enable,
  output logic [7:0]       o_rx_status_byte,
  output logic             o_rx_status_valid
);

  typedef struct packed {
    scsf_regs_t regs;
    logic       sync_lost;
    logic [7:0] rsb;
    logic       rsb_valid;
  } scsf_core_t;

  scsf_core_t st_r;
  scsf_core_t st_nxt;

  logic        wr_stb;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  logic        rd_stb;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        carrier_level;
  logic        carrier_change;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] wmask;
  logic [31:0] status_view;
  logic [31:0] valid_bits;
  logic        async_mode;
  logic        dpll_rx_used;

  scsf_axil_slave u_bus (
    .i_clock   (i_clock),
    .i_rst_b   (i_rst_b),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_stb  (wr_stb),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .o_wr_strb (wr_strb),
    .i_wr_ok   (wr_ok),
    .o_rd_stb  (rd_stb),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_ok   (rd_ok)
  );

  scsf_edge_detect u_carrier (
    .i_clock  (i_clock),
    .i_rst_b  (i_rst_b),
    .i_level  (i_event.carrier_level),
    .o_level  (carrier_level),
    .o_change (carrier_change)
  );

  assign async_mode   = !st_r.regs.config_r[CFG_HDLC];
  assign dpll_rx_used = st_r.regs.config_r[CFG_DPLLRX] &&
                        st_r.regs.config_r[CFG_FMENC];

  // Byte-lane write mask
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wr_strb[b]}};
    end
  end

  // Event set vector
  always_comb begin
    set_vec = '0;
    set_vec[BIT_PARITY] = async_mode && st_r.regs.config_r[CFG_PARITY] &&
                          i_event.parity_err;
    set_vec[BIT_FRAME]  = async_mode && i_event.framing_err;
    set_vec[BIT_SYNC]   = dpll_rx_used && i_event.dpll_lost;
    set_vec[BIT_CARR]   = carrier_change;
    set_vec[BIT_OVFL]   = i_event.fifo_full_drop;
  end

  // Write-one-to-clear vector
  always_comb begin
    clr_vec = '0;
    if (wr_stb && wr_addr == OFF_STATUS) begin
      clr_vec = wr_data & wmask;
    end
  end

  // Bits that exist in the current mode
  always_comb begin
    valid_bits = '0;
    valid_bits[NUM_FLAG:LO_FLAG] = '1;
    if (!async_mode) begin
      valid_bits[BIT_PARITY] = 1'b0;
      valid_bits[BIT_FRAME]  = 1'b0;
    end
  end

  // Status as read: masked flags hidden unless show bit set
  always_comb begin
    status_view = st_r.regs.status & valid_bits;
    if (!st_r.regs.config_r[CFG_SHOW]) begin
      status_view = status_view & ~st_r.regs.mask;
    end
  end

  assign wr_ok = wr_addr == OFF_STATUS || wr_addr == OFF_MASK ||
                 wr_addr == OFF_CONFIG || wr_addr == OFF_LINE;
  assign rd_ok = rd_addr == OFF_STATUS || rd_addr == OFF_MASK ||
                 rd_addr == OFF_CONFIG || rd_addr == OFF_LINE;

  always_comb begin
    rd_data = '0;
    unique case (rd_addr)
      OFF_STATUS: rd_data = status_view;
      OFF_MASK:   rd_data = st_r.regs.mask;
      OFF_CONFIG: rd_data = st_r.regs.config_r;
      OFF_LINE: begin
        rd_data[LINE_CARRIER] = carrier_level;
        rd_data[LINE_SYNC] = !st_r.sync_lost;
      end
      default:    rd_data = '0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    // Set wins over a simultaneous clear; flags otherwise hold
    st_nxt.regs.status = ((st_r.regs.status & ~clr_vec) | set_vec)
                         & valid_bits;
    if (wr_stb && wr_addr == OFF_MASK) begin
      st_nxt.regs.mask = ((st_r.regs.mask & ~wmask) | (wr_data & wmask))
                         & RST_MASK;
    end
    if (wr_stb && wr_addr == OFF_CONFIG) begin
      st_nxt.regs.config_r = (st_r.regs.config_r & ~wmask) |
                             (wr_data & wmask);
    end
    // Sync tracking holds off the receiver until regained
    if (dpll_rx_used && i_event.dpll_lost) begin
      st_nxt.sync_lost = 1'b1;
    end else if (i_event.dpll_regained) begin
      st_nxt.sync_lost = 1'b0;
    end
    st_nxt.rsb_valid = i_event.char_valid && st_r.regs.config_r[CFG_RSBYTE]
                       && o_rx_enable;
    if (i_event.char_valid) begin
      st_nxt.rsb = '0;
      st_nxt.rsb[RSB_PARITY] = st_r.regs.config_r[CFG_PARITY] &&
                               i_event.parity_err;
      st_nxt.rsb[RSB_FRAME]  = i_event.framing_err;
    end
  end

  assign o_rx_enable = !(dpll_rx_used && st_r.sync_lost);
  assign o_tx_enable = !(st_r.regs.config_r[CFG_DPLLTX] &&
                         st_r.sync_lost);
  assign o_rx_status_byte  = st_r.rsb;
  assign o_rx_status_valid = st_r.rsb_valid;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r.regs.status   <= RST_STATUS;
      st_r.regs.mask     <= RST_MASK;
      st_r.regs.config_r <= RST_CONFIG;
      st_r.sync_lost     <= 1'b0;
      st_r.rsb           <= '0;
      st_r.rsb_valid     <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Checks
  a_parity_sets: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    set_vec[BIT_PARITY] |=> st_r.regs.status[BIT_PARITY])
    else $error("parity flag not set");
  a_parity_gated: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !st_r.regs.config_r[CFG_PARITY] && !st_r.regs.status[BIT_PARITY]
    |=> !st_r.regs.status[BIT_PARITY])
    else $error("parity flag set while checking off");
  a_rsb_parity: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_event.char_valid && i_event.parity_err &&
    st_r.regs.config_r[CFG_PARITY] |=> st_r.rsb[RSB_PARITY])
    else $error("status byte lacks parity");
  a_frame_sets: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    async_mode && i_event.framing_err |=> st_r.regs.status[BIT_FRAME])
    else $error("framing flag not set");
  a_hdlc_zero: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (status_view[9:4] == '0 || async_mode) && !status_view[0])
    else $error("reserved bits nonzero");
  a_sync_sets: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    dpll_rx_used && i_event.dpll_lost
    |=> st_r.regs.status[BIT_SYNC] && !o_rx_enable)
    else $error("sync loss not flagged");
  a_rx_hold: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !o_rx_enable && !i_event.dpll_regained |=> !o_rx_enable)
    else $error("receiver resumed early");
  a_tx_hold: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    st_r.sync_lost && st_r.regs.config_r[CFG_DPLLTX] |-> !o_tx_enable)
    else $error("transmit not halted");
  a_carrier_change: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    carrier_change |=> st_r.regs.status[BIT_CARR])
    else $error("carrier change not flagged");
  a_ovfl_sets: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    i_event.fifo_full_drop |=> st_r.regs.status[BIT_OVFL])
    else $error("overflow flag not set");
  a_mask_hide: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    !st_r.regs.config_r[CFG_SHOW] |-> (status_view & st_r.regs.mask) == '0)
    else $error("masked flag visible");
  a_w1c_clear: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    clr_vec[BIT_OVFL] && !set_vec[BIT_OVFL] |=> !st_r.regs.status[BIT_OVFL])
    else $error("write one did not clear");
  a_set_wins: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    clr_vec[BIT_OVFL] && set_vec[BIT_OVFL] |=> st_r.regs.status[BIT_OVFL])
    else $error("event lost on clear");
  a_flag_holds: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    st_r.regs.status[BIT_OVFL] && !clr_vec[BIT_OVFL]
    |=> st_r.regs.status[BIT_OVFL])
    else $error("flag dropped itself");

endmodule

// ---- shared/scsf_pkg.sv ----
// Shared constants and carrier types for the serial channel status flags.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock.
package scsf_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_MASK   = 8'h04;
  localparam logic [7:0] OFF_CONFIG = 8'h08;
  localparam logic [7:0] OFF_LINE   = 8'h0c;

  // Status flag positions
  localparam int BIT_OVFL   = 1;
  localparam int BIT_CARR   = 2;
  localparam int BIT_SYNC   = 3;
  localparam int BIT_FRAME  = 4;
  localparam int BIT_PARITY = 5;
  localparam int NUM_FLAG = 5;
  localparam int LO_FLAG  = 1;

  // Config register field positions
  localparam int CFG_SHOW   = 0;
  localparam int CFG_PARITY = 1;
  localparam int CFG_RSBYTE = 2;
  localparam int CFG_HDLC   = 3;
  localparam int CFG_DPLLRX = 4;
  localparam int CFG_DPLLTX = 5;
  localparam int CFG_FMENC  = 6;

  // Line status field positions
  localparam int LINE_CARRIER = 0;
  localparam int LINE_SYNC  = 1;

  // Reset values
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_MASK   = 32'h0000_003e;
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Receive status byte positions
  localparam int RSB_PARITY = 0;
  localparam int RSB_FRAME  = 1;

  typedef struct packed {
    logic parity_err;
    logic framing_err;
    logic dpll_lost;
    logic dpll_regained;
    logic carrier_level;
    logic fifo_full_drop;
    logic char_valid;
  } scsf_event_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] config_r;
  } scsf_regs_t;

endpackage

// ---- testbench/scsf_status_flags_tb.sv ----
// Self-checking bench for the channel status flags block.
// Assumes the block answers AXI4-Lite requests and samples event pulses.
`timescale 1ns/100ps
module scsf_status_flags_tb;
  import scsf_pkg::*;
  logic        clock;
  logic        rst_b;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  scsf_event_t ev;
  logic        rx_en;
  logic        tx_en;
  logic [7:0]  sbyte;
  logic        svalid;
  logic        cap_sv;
  logic        cap_rx;
  logic        cap_tx;
  logic [7:0]  cap_sb;
  logic [1:0]  cap_br;
  int          failures;
  int          tests_run;

  scsf_status_flags u_dut (
    .i_clock(clock), .i_rst_b(rst_b),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_event(ev), .o_rx_enable(rx_en), .o_tx_enable(tx_en),
    .o_rx_status_byte(sbyte), .o_rx_status_valid(svalid)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check32(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    cap_br = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check32(e, d);
  endtask

  // Pulse the given event bits for one sampling edge and capture outputs
  task automatic pulse(input scsf_event_t m);
    ev <= ev | m;
    @(posedge clock);
    ev <= ev & ~m;
    @(negedge clock);
    cap_sv = svalid;
    cap_sb = sbyte;
    cap_rx = rx_en;
    cap_tx = tx_en;
    @(posedge clock);
  endtask

  function automatic scsf_event_t evm(input int b);
    return scsf_event_t'(7'h1 << b);
  endfunction

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(OFF_STATUS, RST_STATUS);
    rd_chk(OFF_MASK, RST_MASK);
    rd_chk(OFF_CONFIG, RST_CONFIG);
    axi_read(8'h40, d, r);
    check32({30'h0, RESP_SLVERR}, {30'h0, r});
    check32(32'h0, d);
    axi_write(8'h40, 32'hffff_ffff);
    check32({30'h0, RESP_SLVERR}, {30'h0, cap_br});
    axi_write(OFF_MASK, 32'h0);
    check32({30'h0, RESP_OKAY}, {30'h0, cap_br});
    $display("reset test done");
  endtask

  task automatic t_overflow;
    pulse(evm(1));
    rd_chk(OFF_STATUS, 32'h1 << BIT_OVFL);
    axi_write(OFF_STATUS, 32'h0);
    rd_chk(OFF_STATUS, 32'h1 << BIT_OVFL);
    axi_write(OFF_STATUS, 32'hffff_fffd);
    rd_chk(OFF_STATUS, 32'h1 << BIT_OVFL);
    axi_write(OFF_STATUS, 32'h1 << BIT_OVFL);
    rd_chk(OFF_STATUS, 32'h0);
    $display("overflow test done");
  endtask

  task automatic t_parity;
    pulse(evm(6));
    rd_chk(OFF_STATUS, 32'h0);
    axi_write(OFF_CONFIG, (32'h1 << CFG_PARITY) | (32'h1 << CFG_RSBYTE));
    pulse(evm(6) | evm(0));
    check32(32'h1, {31'h0, cap_sv});
    check32(32'h1 << RSB_PARITY, {24'h0, cap_sb});
    rd_chk(OFF_STATUS, 32'h1 << BIT_PARITY);
    axi_write(OFF_STATUS, 32'h1 << BIT_PARITY);
    $display("parity test done");
  endtask

  task automatic t_framing;
    pulse(evm(5));
    rd_chk(OFF_STATUS, 32'h1 << BIT_FRAME);
    axi_write(OFF_CONFIG, 32'h1 << CFG_HDLC);
    pulse(evm(1) | evm(5));
    rd_chk(OFF_STATUS, 32'h1 << BIT_OVFL);
    axi_write(OFF_STATUS, 32'h3f);
    axi_write(OFF_CONFIG, 32'h0);
    rd_chk(OFF_STATUS, 32'h0);
    $display("framing test done");
  endtask

  task automatic t_dpll;
    pulse(evm(4));
    rd_chk(OFF_STATUS, 32'h0);
    axi_write(OFF_CONFIG, (32'h1 << CFG_DPLLRX) | (32'h1 << CFG_DPLLTX)
                          | (32'h1 << CFG_FMENC));
    pulse(evm(4));
    check32(32'h0, {31'h0, cap_rx});
    check32(32'h0, {31'h0, cap_tx});
    rd_chk(OFF_STATUS, 32'h1 << BIT_SYNC);
    pulse(evm(3));
    check32(32'h1, {31'h0, cap_rx});
    check32(32'h1, {31'h0, cap_tx});
    axi_write(OFF_STATUS, 32'h1 << BIT_SYNC);
    axi_write(OFF_CONFIG, 32'h0);
    $display("dpll test done");
  endtask

  task automatic t_carrier;
    ev.carrier_level <= 1'b1;
    repeat (3) @(posedge clock);
    rd_chk(OFF_STATUS, 32'h1 << BIT_CARR);
    rd_chk(OFF_LINE, (32'h1 << LINE_CARRIER) | (32'h1 << LINE_SYNC));
    axi_write(OFF_STATUS, 32'h1 << BIT_CARR);
    ev.carrier_level <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk(OFF_STATUS, 32'h1 << BIT_CARR);
    axi_write(OFF_STATUS, 32'h1 << BIT_CARR);
    $display("carrier test done");
  endtask

  task automatic t_visibility;
    axi_write(OFF_MASK, RST_MASK);
    pulse(evm(1));
    rd_chk(OFF_STATUS, 32'h0);
    axi_write(OFF_CONFIG, 32'h1 << CFG_SHOW);
    rd_chk(OFF_STATUS, 32'h1 << BIT_OVFL);
    axi_write(OFF_STATUS, 32'h1 << BIT_OVFL);
    axi_write(OFF_MASK, 32'h0);
    $display("visibility test done");
  endtask

  task automatic t_set_wins;
    ev.fifo_full_drop <= 1'b1;
    axi_write(OFF_STATUS, 32'h1 << BIT_OVFL);
    ev.fifo_full_drop <= 1'b0;
    @(posedge clock);
    rd_chk(OFF_STATUS, 32'h1 << BIT_OVFL);
    axi_write(OFF_STATUS, 32'h1 << BIT_OVFL);
    $display("set versus clear test done");
  endtask

  initial begin
    #(50 * 20000);
    failures++;
    finish_test();
  end

  initial begin
    failures  = 0;
    tests_run = 0;
    rst_b   = 1'b0;
    awaddr  = 8'h0;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h0;
    arvalid = 1'b0;
    rready  = 1'b0;
    ev      = '0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset();
    t_overflow();
    t_parity();
    t_framing();
    t_dpll();
    t_carrier();
    t_visibility();
    t_set_wins();
    finish_test();
  end
endmodule
